// >>> pdcd_regs.sv
/*
  APB register bank for receive DSP training and cable diagnostics, with
  gain index clamping, retrain gating and an event interrupt.
  Assumes a 32-bit APB master on pclk and DSP logic on the same clock.
*/
// Notes on behaviour
// - writing one to start bit 15 launches the test; zero does nothing
// - status bit 12 reads one while the test runs, zero when done
// - bit 14 clear enables cross-pair mode to find inter-pair shorts
// - bit 13 set skips reflectometry on the transmit pair
// - bit 12 set skips reflectometry on the receive pair
// - bits 10:8 give two-to-the-code averaging; 111 reserved; reset 110
// - bits 3:0 of control two set expected self-reflection; reset 1100
// - retrain-disable bit 11 set blocks gain retraining; reset zero
// - gain index kept between max limit 7:4 and min limit 3:0
// - gain training starts from index in bits 3:0, reset 011
// - bit 8 selects gain correction loop input kind; reset one
// - 15-bit recovery error threshold for 100 Mbps steady state
// - 15-bit good error threshold for the timing loop
// - second 15-bit good error threshold for declaring link-up
// - training timers in bits 14:12, 11:6, 5:3 and 2:0
`timescale 1ns/1ps
module pdcd_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pdcd_pkg::pdcd_test_rsp_t test_rsp,
  output logic test_start,
  input wire logic [3:0] gain_idx_req,
  output logic [3:0] gain_idx,
  input wire logic retrain_req,
  output logic retrain_go,
  output pdcd_pkg::pdcd_dsp_cfg_t dsp_cfg,
  output logic irq
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [15:0] reg_r [pdcd_pkg::NREG];
  logic [15:0] reg_nxt [pdcd_pkg::NREG];
  logic [pdcd_pkg::NREG-1:0] hit;
  logic [8:0] idx;
  logic setup;
  logic access;
  logic wr_en;
  logic rd_en;
  logic launch;
  logic hit_status;
  logic hit_mask;
  logic mapped;
  logic [15:0] rd_word;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  logic [pdcd_pkg::NEV-1:0] status_r;
  logic [pdcd_pkg::NEV-1:0] status_nxt;
  logic [pdcd_pkg::NEV-1:0] mask_r;
  logic [pdcd_pkg::NEV-1:0] mask_nxt;
  logic [pdcd_pkg::NEV-1:0] events;
  logic [pdcd_pkg::NEV-1:0] clr;
  logic irq_r;
  logic irq_nxt;
  logic [3:0] gain_idx_r;
  logic [3:0] gain_idx_nxt;
  logic retrain_go_r;
  logic retrain_go_nxt;
  logic test_busy;
  logic test_done;
  logic [7:0] test_sum;
  logic [3:0] lim_max;
  logic [3:0] lim_min;
  logic [2:0] avg_raw;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  assign idx = paddr[10:2];
  assign setup = ce && psel && !penable;
  assign access = ce && psel && penable && pready_r;
  assign wr_en = access && pwrite;
  assign rd_en = access && !pwrite;
  assign hit_status = (idx == pdcd_pkg::IDX_EVT_STATUS);
  assign hit_mask = (idx == pdcd_pkg::IDX_EVT_MASK);
  assign mapped = !paddr[11] && ((|hit) || hit_status || hit_mask);
  assign launch = wr_en && !paddr[11] && hit[pdcd_pkg::R_ACTIVE_TEST] &&
                  pwdata[pdcd_pkg::B_TEST_START];

  genvar gi;
  generate
    for (gi = 0; gi < pdcd_pkg::NREG; gi++) begin : g_hit
      assign hit[gi] = (idx == pdcd_pkg::REG_IDX[gi]);
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Read data and bus answer
  // ----------------------------------------------------------------------
  always_comb begin
    rd_word = 16'h0000;
    for (int i = 0; i < pdcd_pkg::NREG; i++) begin
      if (hit[i]) begin
        rd_word = reg_r[i];
      end
    end
    if (hit[pdcd_pkg::R_ACTIVE_TEST]) begin
      // Start bit self-clears and always reads zero.
      rd_word[pdcd_pkg::B_TEST_START] = 1'b0;
      rd_word[pdcd_pkg::B_TEST_BUSY] = test_busy;
      rd_word[pdcd_pkg::SUM_MSB:pdcd_pkg::SUM_LSB] = test_sum;
    end
    if (hit_status) begin
      rd_word = {14'h0000, status_r};
    end
    if (hit_mask) begin
      rd_word = {14'h0000, mask_r};
    end
    if (paddr[11]) begin
      rd_word = 16'h0000;
    end
  end

  // Answer is prepared in the setup cycle, so every access phase is one
  // cycle long and back-to-back transfers need no idle cycle.
  always_comb begin
    pready_nxt = setup;
    prdata_nxt = prdata_r;
    pslverr_nxt = pslverr_r;
    if (setup) begin
      prdata_nxt = {16'h0000, rd_word};
      pslverr_nxt = !mapped;
    end else if (access) begin
      pslverr_nxt = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else if (ce) begin
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  // ----------------------------------------------------------------------
  // Configuration storage
  // ----------------------------------------------------------------------
  // Read-only and self-clearing bits keep their reset value.
  always_comb begin
    for (int i = 0; i < pdcd_pkg::NREG; i++) begin
      reg_nxt[i] = reg_r[i];
      if (wr_en && !paddr[11] && hit[i]) begin
        reg_nxt[i] = (pwdata[15:0] & pdcd_pkg::REG_WMASK[i]) |
                     (pdcd_pkg::REG_RST[i] & ~pdcd_pkg::REG_WMASK[i]);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < pdcd_pkg::NREG; i++) begin
        reg_r[i] <= pdcd_pkg::REG_RST[i];
      end
    end else if (ce) begin
      for (int i = 0; i < pdcd_pkg::NREG; i++) begin
        reg_r[i] <= reg_nxt[i];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Active-link cable test
  // ----------------------------------------------------------------------
  pdcd_test_seq u_test_seq (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .launch(launch),
    .rsp(test_rsp),
    .start_r(test_start),
    .busy_r(test_busy),
    .done_r(test_done),
    .sum_r(test_sum)
  );

  // ----------------------------------------------------------------------
  // Configuration outputs
  // ----------------------------------------------------------------------
  assign avg_raw = reg_r[pdcd_pkg::R_REFL_CTRL]
                   [pdcd_pkg::AVG_MSB:pdcd_pkg::AVG_LSB];
  assign lim_max = reg_r[pdcd_pkg::R_GAIN_LIMITS]
                   [pdcd_pkg::MAXG_MSB:pdcd_pkg::MAXG_LSB];
  assign lim_min = reg_r[pdcd_pkg::R_GAIN_LIMITS]
                   [pdcd_pkg::NIB_MSB:pdcd_pkg::NIB_LSB];

  always_comb begin
    dsp_cfg.cross_pair_en =
      !reg_r[pdcd_pkg::R_REFL_CTRL][pdcd_pkg::B_CROSS_DIS];
    dsp_cfg.run_transmit_pair =
      !reg_r[pdcd_pkg::R_REFL_CTRL][pdcd_pkg::B_TX_BYPASS];
    dsp_cfg.run_receive_pair =
      !reg_r[pdcd_pkg::R_REFL_CTRL][pdcd_pkg::B_RX_BYPASS];
    // The reserved averaging code runs as the largest legal count.
    dsp_cfg.avg_code = (avg_raw == pdcd_pkg::AVG_RESERVED) ?
                       pdcd_pkg::AVG_LARGEST : avg_raw;
    dsp_cfg.pulse_level = reg_r[pdcd_pkg::R_REFL_CTRL_TWO]
                          [pdcd_pkg::NIB_MSB:pdcd_pkg::NIB_LSB];
    dsp_cfg.retrain_allowed =
      !reg_r[pdcd_pkg::R_RETRAIN][pdcd_pkg::B_RETRAIN_DIS];
    dsp_cfg.max_gain_idx = lim_max;
    dsp_cfg.min_gain_idx = lim_min;
    dsp_cfg.start_gain_idx = reg_r[pdcd_pkg::R_START_GAIN]
                             [pdcd_pkg::NIB_MSB:pdcd_pkg::NIB_LSB];
    dsp_cfg.loop_input_sel =
      reg_r[pdcd_pkg::R_LOOP_INPUT][pdcd_pkg::B_LOOP_SEL];
    dsp_cfg.recovery_thr = reg_r[pdcd_pkg::R_RECOVERY_THR]
                           [pdcd_pkg::THR_MSB:0];
    dsp_cfg.timing_loop_good_error = reg_r[pdcd_pkg::R_TIMING_THR]
                                     [pdcd_pkg::THR_MSB:0];
    dsp_cfg.linkup_good_error = reg_r[pdcd_pkg::R_LINKUP_THR]
                                [pdcd_pkg::THR_MSB:0];
    dsp_cfg.shift_timer = reg_r[pdcd_pkg::R_TRAIN_TIMER]
                          [pdcd_pkg::T1_MSB:pdcd_pkg::T1_LSB];
    dsp_cfg.timing_timer = reg_r[pdcd_pkg::R_TRAIN_TIMER]
                           [pdcd_pkg::T2_MSB:pdcd_pkg::T2_LSB];
    dsp_cfg.gain_timer_a = reg_r[pdcd_pkg::R_TRAIN_TIMER]
                           [pdcd_pkg::T3_MSB:pdcd_pkg::T3_LSB];
    dsp_cfg.gain_timer_b = reg_r[pdcd_pkg::R_TRAIN_TIMER]
                           [pdcd_pkg::T4_MSB:0];
  end

  // ----------------------------------------------------------------------
  // Gain index clamp and retrain gate
  // ----------------------------------------------------------------------
  // Higher gain sits at the lower index, so the max limit is the floor.
  always_comb begin
    gain_idx_nxt = gain_idx_req;
    if (gain_idx_req < lim_max) begin
      gain_idx_nxt = lim_max;
    end else if (gain_idx_req > lim_min) begin
      gain_idx_nxt = lim_min;
    end
    retrain_go_nxt = retrain_req && dsp_cfg.retrain_allowed;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gain_idx_r <= 4'h0;
      retrain_go_r <= 1'b0;
    end else if (ce) begin
      gain_idx_r <= gain_idx_nxt;
      retrain_go_r <= retrain_go_nxt;
    end
  end

  assign gain_idx = gain_idx_r;
  assign retrain_go = retrain_go_r;

  // ----------------------------------------------------------------------
  // Events and interrupt
  // ----------------------------------------------------------------------
  // Only bits returned by the read are cleared, so a new event wins.
  always_comb begin
    events = '0;
    events[pdcd_pkg::EV_TEST_DONE] = test_done;
    events[pdcd_pkg::EV_AVG_RSV] = wr_en && !paddr[11] &&
      hit[pdcd_pkg::R_REFL_CTRL] &&
      (pwdata[pdcd_pkg::AVG_MSB:pdcd_pkg::AVG_LSB] ==
       pdcd_pkg::AVG_RESERVED);
    clr = (rd_en && !paddr[11] && hit_status) ?
          prdata_r[pdcd_pkg::NEV-1:0] : '0;
    status_nxt = (status_r & ~clr) | events;
    mask_nxt = mask_r;
    if (wr_en && !paddr[11] && hit_mask) begin
      mask_nxt = pwdata[pdcd_pkg::NEV-1:0];
    end
    irq_nxt = |(status_r & mask_r);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= '0;
      mask_r <= '0;
      irq_r <= 1'b0;
    end else if (ce) begin
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign irq = irq_r;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  start_launch_a: assert property (
    launch && !test_busy |=> test_start && test_busy)
    else $error("test did not start after start bit write");

  start_zero_a: assert property (
    ce && wr_en && hit[pdcd_pkg::R_ACTIVE_TEST] &&
    !pwdata[pdcd_pkg::B_TEST_START] |=> !test_start)
    else $error("test started on a zero write");

  test_busy_a: assert property (
    ce && test_busy && !test_rsp.done |=> test_busy ##0 !test_done)
    else $error("busy dropped while test still running");

  test_done_a: assert property (
    ce && test_busy && test_rsp.done |=> !test_busy && test_done &&
    test_sum == $past(test_rsp.sum))
    else $error("busy not cleared or sum not captured at completion");

  cross_mode_a: assert property (
    wr_en && hit[pdcd_pkg::R_REFL_CTRL] && !paddr[11] |=>
    dsp_cfg.cross_pair_en == !$past(pwdata[pdcd_pkg::B_CROSS_DIS]) &&
    dsp_cfg.run_transmit_pair == !$past(pwdata[pdcd_pkg::B_TX_BYPASS]) &&
    dsp_cfg.run_receive_pair == !$past(pwdata[pdcd_pkg::B_RX_BYPASS]))
    else $error("pair selection does not follow written control");

  avg_legal_a: assert property (
    dsp_cfg.avg_code != pdcd_pkg::AVG_RESERVED)
    else $error("reserved averaging code reached the reflectometer");

  pulse_level_a: assert property (
    wr_en && hit[pdcd_pkg::R_REFL_CTRL_TWO] && !paddr[11] |=>
    dsp_cfg.pulse_level == $past(pwdata[3:0]))
    else $error("pulse level did not take the written value");

  retrain_gate_a: assert property (
    ce && !dsp_cfg.retrain_allowed |=> !retrain_go)
    else $error("retrain issued while disabled");

  gain_range_a: assert property (
    ce && lim_max <= lim_min |=>
    gain_idx >= $past(lim_max) && gain_idx <= $past(lim_min))
    else $error("gain index left its limits");

  irq_level_a: assert property (
    ce |=> irq == $past(|(status_r & mask_r)))
    else $error("interrupt does not follow masked status");

endmodule

// >>> pdcd_pkg.sv
/*
  Constants, register map and carrier types for the receive DSP training
  and cable diagnostic register bank.
  Assumes a 32-bit APB slave with word registers at four times the index.
*/
package pdcd_pkg;

  // ----------------------------------------------------------------------
  // Bus and map geometry
  // ----------------------------------------------------------------------
  localparam int PADDR_W = 12;
  localparam int IDX_W = 9;
  localparam int NREG = 14;
  localparam int NEV = 2;

  localparam logic [8:0] IDX_FILTER_TWO = 9'h107;
  localparam logic [8:0] IDX_LOOP_INPUT = 9'h10f;
  localparam logic [8:0] IDX_START_GAIN = 9'h111;
  localparam logic [8:0] IDX_FEEDBACK_EQ = 9'h114;
  localparam logic [8:0] IDX_GAIN_BW = 9'h116;
  localparam logic [8:0] IDX_RECOVERY_THR = 9'h121;
  localparam logic [8:0] IDX_TIMING_THR = 9'h122;
  localparam logic [8:0] IDX_LINKUP_THR = 9'h123;
  localparam logic [8:0] IDX_TRAIN_TIMER = 9'h126;
  localparam logic [8:0] IDX_GAIN_LIMITS = 9'h129;
  localparam logic [8:0] IDX_RETRAIN = 9'h130;
  localparam logic [8:0] IDX_ACTIVE_TEST = 9'h155;
  localparam logic [8:0] IDX_REFL_CTRL = 9'h170;
  localparam logic [8:0] IDX_REFL_CTRL_TWO = 9'h171;
  localparam logic [8:0] IDX_EVT_STATUS = 9'h1f0;
  localparam logic [8:0] IDX_EVT_MASK = 9'h1f1;

  // Slot of each register in the storage array.
  localparam int R_LOOP_INPUT = 1;
  localparam int R_START_GAIN = 2;
  localparam int R_RECOVERY_THR = 5;
  localparam int R_TIMING_THR = 6;
  localparam int R_LINKUP_THR = 7;
  localparam int R_TRAIN_TIMER = 8;
  localparam int R_GAIN_LIMITS = 9;
  localparam int R_RETRAIN = 10;
  localparam int R_ACTIVE_TEST = 11;
  localparam int R_REFL_CTRL = 12;
  localparam int R_REFL_CTRL_TWO = 13;

  localparam logic [8:0] REG_IDX [NREG] = '{
    IDX_FILTER_TWO, IDX_LOOP_INPUT, IDX_START_GAIN, IDX_FEEDBACK_EQ,
    IDX_GAIN_BW, IDX_RECOVERY_THR, IDX_TIMING_THR, IDX_LINKUP_THR,
    IDX_TRAIN_TIMER, IDX_GAIN_LIMITS, IDX_RETRAIN, IDX_ACTIVE_TEST,
    IDX_REFL_CTRL, IDX_REFL_CTRL_TWO};
  localparam logic [15:0] REG_RST [NREG] = '{
    16'h0605, 16'h0300, 16'h6003, 16'h400a, 16'h014a, 16'h199a,
    16'h1027, 16'h051c, 16'h461b, 16'h000f, 16'h0001, 16'h0001,
    16'h0e52, 16'hc85c};
  // Bits that software may change; the rest hold their reset value.
  localparam logic [15:0] REG_WMASK [NREG] = '{
    16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'h7fff,
    16'h7fff, 16'h7fff, 16'hffff, 16'hffff, 16'hffff, 16'h000f,
    16'h7fff, 16'hffff};

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int B_TEST_START = 15;
  localparam int B_TEST_BUSY = 12;
  localparam int SUM_LSB = 4;
  localparam int SUM_MSB = 11;
  localparam int B_CROSS_DIS = 14;
  localparam int B_TX_BYPASS = 13;
  localparam int B_RX_BYPASS = 12;
  localparam int AVG_LSB = 8;
  localparam int AVG_MSB = 10;
  localparam int NIB_LSB = 0;
  localparam int NIB_MSB = 3;
  localparam int MAXG_LSB = 4;
  localparam int MAXG_MSB = 7;
  localparam int B_RETRAIN_DIS = 11;
  localparam int B_LOOP_SEL = 8;
  localparam int THR_MSB = 14;
  localparam int T1_LSB = 12;
  localparam int T1_MSB = 14;
  localparam int T2_LSB = 6;
  localparam int T2_MSB = 11;
  localparam int T3_LSB = 3;
  localparam int T3_MSB = 5;
  localparam int T4_MSB = 2;
  localparam logic [2:0] AVG_RESERVED = 3'h7;
  localparam logic [2:0] AVG_LARGEST = 3'h6;
  localparam int EV_TEST_DONE = 0;
  localparam int EV_AVG_RSV = 1;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic cross_pair_en;
    logic run_transmit_pair;
    logic run_receive_pair;
    logic [2:0] avg_code;
    logic [3:0] pulse_level;
    logic retrain_allowed;
    logic [3:0] max_gain_idx;
    logic [3:0] min_gain_idx;
    logic [3:0] start_gain_idx;
    logic loop_input_sel;
    logic [14:0] recovery_thr;
    logic [14:0] timing_loop_good_error;
    logic [14:0] linkup_good_error;
    logic [2:0] shift_timer;
    logic [5:0] timing_timer;
    logic [2:0] gain_timer_a;
    logic [2:0] gain_timer_b;
  } pdcd_dsp_cfg_t;

  typedef struct packed {
    logic done;
    logic [7:0] sum;
  } pdcd_test_rsp_t;

endpackage

// >>> pdcd_test_seq.sv
/*
  Tracker for the active-link cable test: launches it and holds the busy
  flag and result until the diagnostic engine reports completion.
  Assumes the engine runs on pclk and pulses done for one cycle.
*/
`timescale 1ns/1ps
module pdcd_test_seq (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic launch,
  input wire pdcd_pkg::pdcd_test_rsp_t rsp,
  output logic start_r,
  output logic busy_r,
  output logic done_r,
  output logic [7:0] sum_r
);

  typedef enum logic {PDCD_IDLE, PDCD_RUN} pdcd_tstate_t;

  pdcd_tstate_t state_r;
  pdcd_tstate_t state_nxt;
  logic start_nxt;
  logic done_nxt;
  logic [7:0] sum_nxt;

  // A launch while a test runs is ignored; the running test finishes.
  always_comb begin
    state_nxt = state_r;
    start_nxt = 1'b0;
    done_nxt = 1'b0;
    sum_nxt = sum_r;
    case (state_r)
      PDCD_IDLE: begin
        if (launch) begin
          state_nxt = PDCD_RUN;
          start_nxt = 1'b1;
        end
      end
      PDCD_RUN: begin
        if (rsp.done) begin
          state_nxt = PDCD_IDLE;
          done_nxt = 1'b1;
          sum_nxt = rsp.sum;
        end
      end
      default: state_nxt = PDCD_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= PDCD_IDLE;
      start_r <= 1'b0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      sum_r <= 8'h00;
    end else if (ce) begin
      state_r <= state_nxt;
      start_r <= start_nxt;
      busy_r <= (state_nxt == PDCD_RUN);
      done_r <= done_nxt;
      sum_r <= sum_nxt;
    end
  end

endmodule

// >>> pdcd_regs_tb.sv
/*
  Self-checking bench for the DSP training and cable diagnostic registers.
  Assumes the design answers APB with pready and ce may stay high.
*/
`timescale 1ns/1ps
module pdcd_regs_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, test_start, retrain_go, irq, serr;
  logic [3:0] gain_idx_req = 4'h0;
  logic [3:0] gain_idx;
  logic retrain_req = 1'b0;
  logic ce = 1'b1;
  pdcd_pkg::pdcd_test_rsp_t test_rsp = '0;
  pdcd_pkg::pdcd_dsp_cfg_t dsp_cfg, cfg_exp;
  int error_cnt = 0;
  int compares = 0;
  int starts = 0;
  logic [31:0] rdat;
  logic [2:0] c3;
  logic [15:0] wv;
  logic [3:0] gq [3] = '{4'h0, 4'h5, 4'hf};
  logic [3:0] ge [3] = '{4'h2, 4'h5, 4'h9};
  logic [15:0] tw [3] = '{16'hffff, 16'h1234, 16'h8abc};

  always #20 pclk = ~pclk;
  always @(posedge pclk) if (test_start === 1'b1) starts <= starts + 1;

  pdcd_regs dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .test_rsp(test_rsp), .test_start(test_start),
    .gain_idx_req(gain_idx_req), .gain_idx(gain_idx),
    .retrain_req(retrain_req), .retrain_go(retrain_go),
    .dsp_cfg(dsp_cfg), .irq(irq));

  // ----------------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------------
  function automatic logic [11:0] ba(input logic [8:0] i);
    return {1'b0, i, 2'b00};
  endfunction

  task automatic chk(input string nm, input logic [95:0] e,
                     input logic [95:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  // Holds the request until pready is sampled high, then releases it.
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [15:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task automatic wr(input logic [8:0] i, input logic [15:0] d);
    xfer(1'b1, ba(i), d);
  endtask

  task automatic rd(input logic [8:0] i, input logic [15:0] e,
                    input string nm);
    xfer(1'b0, ba(i), 16'h0000);
    chk(nm, 96'({16'h0000, e}), 96'(rdat));
  endtask

  task automatic settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask

  task automatic report_and_stop();
    if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge pclk);
    error_cnt++;
    report_and_stop();
  end

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    cfg_exp = '{1'b1, 1'b1, 1'b1, 3'h6, 4'hc, 1'b1, 4'h0, 4'hf, 4'h3, 1'b1,
      15'h199a, 15'h1027, 15'h051c, 3'h4, 6'h18, 3'h3, 3'h3};
    chk("cfg rst", 96'(cfg_exp), 96'(dsp_cfg));
    for (int i = 0; i < pdcd_pkg::NREG; i++)
      rd(pdcd_pkg::REG_IDX[i], pdcd_pkg::REG_RST[i], "rst");
    xfer(1'b1, 12'h800, 16'hffff);
    xfer(1'b0, 12'h800, 16'h0000);
    chk("unmapped", 96'({1'b1, 32'h0000_0000}), 96'({serr, rdat}));
    // Pair skips, cross mode and every averaging code, 111 included.
    for (int c = 0; c < 8; c++) begin
      c3 = 3'(c);
      wv = {1'b0, c3, 1'b1, c3, 8'h52};
      wr(pdcd_pkg::IDX_REFL_CTRL, wv);
      chk("pairs", 96'({~c3}), 96'({dsp_cfg.cross_pair_en,
        dsp_cfg.run_transmit_pair,
        dsp_cfg.run_receive_pair}));
      chk("avg", 96'((c3 == 3'h7) ? 3'h6 : c3),
        96'(dsp_cfg.avg_code));
      rd(pdcd_pkg::IDX_REFL_CTRL, wv, "refl rd");
    end
    wr(pdcd_pkg::IDX_REFL_CTRL_TWO, 16'hc853);
    chk("pulse", 96'(4'h3), 96'(dsp_cfg.pulse_level));
    @(posedge pclk);
    retrain_req <= 1'b1;
    settle();
    chk("retrain on", 96'(1'b1), 96'(retrain_go));
    wr(pdcd_pkg::IDX_RETRAIN, 16'h0801);
    settle();
    chk("retrain off", 96'(1'b0), 96'(retrain_go));
    @(posedge pclk);
    retrain_req <= 1'b0;
    wr(pdcd_pkg::IDX_GAIN_LIMITS, 16'h0029);
    for (int k = 0; k < 3; k++) begin
      @(posedge pclk);
      gain_idx_req <= gq[k];
      settle();
      chk("gain", 96'(ge[k]), 96'(gain_idx));
    end
    // Clock enable low freezes the clamped index.
    @(posedge pclk);
    ce <= 1'b0;
    gain_idx_req <= 4'h0;
    settle();
    chk("ce hold", 96'(4'h9), 96'(gain_idx));
    @(posedge pclk);
    ce <= 1'b1;
    settle();
    chk("ce run", 96'(4'h2), 96'(gain_idx));
    wr(pdcd_pkg::IDX_START_GAIN, 16'h6007);
    wr(pdcd_pkg::IDX_LOOP_INPUT, 16'h0200);
    chk("start sel", 96'({4'h7, 1'b0}), 96'({dsp_cfg.start_gain_idx,
      dsp_cfg.loop_input_sel}));
    for (int k = 0; k < 3; k++) begin
      wr(pdcd_pkg::IDX_RECOVERY_THR + 9'(k), tw[k]);
      rd(pdcd_pkg::IDX_RECOVERY_THR + 9'(k), tw[k] & 16'h7fff, "thr");
    end
    chk("thr", 96'({15'h7fff, 15'h1234, 15'h0abc}), 96'({
      dsp_cfg.recovery_thr, dsp_cfg.timing_loop_good_error,
      dsp_cfg.linkup_good_error}));
    wr(pdcd_pkg::IDX_TRAIN_TIMER, 16'h2ad1);
    chk("timers", 96'({3'h2, 6'h2b, 3'h2, 3'h1}), 96'({dsp_cfg.shift_timer,
      dsp_cfg.timing_timer, dsp_cfg.gain_timer_a,
      dsp_cfg.gain_timer_b}));
    // Cable test: zero start bit, launch, busy, completion and interrupt.
    wr(pdcd_pkg::IDX_EVT_MASK, 16'h0000);
    wr(pdcd_pkg::IDX_ACTIVE_TEST, 16'h0001);
    settle();
    chk("no start", 96'(0), 96'(starts));
    wr(pdcd_pkg::IDX_ACTIVE_TEST, 16'h8001);
    settle();
    chk("start", 96'(1), 96'(starts));
    rd(pdcd_pkg::IDX_ACTIVE_TEST, 16'h1001, "busy");
    @(posedge pclk);
    test_rsp <= '{done: 1'b1, sum: 8'ha5};
    @(posedge pclk);
    test_rsp <= '0;
    settle();
    chk("irq masked", 96'(1'b0), 96'(irq));
    rd(pdcd_pkg::IDX_ACTIVE_TEST, 16'h0a51, "done");
    wr(pdcd_pkg::IDX_EVT_MASK, 16'h0001);
    settle();
    chk("irq", 96'(1'b1), 96'(irq));
    rd(pdcd_pkg::IDX_EVT_STATUS, 16'h0003, "status");
    rd(pdcd_pkg::IDX_EVT_STATUS, 16'h0000, "cleared");
    settle();
    chk("irq clr", 96'(1'b0), 96'(irq));
    report_and_stop();
  end
endmodule
